// ### verilog/cise_pkg.sv
// Package: opcodes, field layout and reset values for the instruction subset executor
package cise_pkg;
  // ----------------------------------------
  // Operation select codes
  // ----------------------------------------
  typedef enum logic [3:0] {
    CISE_NOP = 4'h0,
    CISE_DEC_SKIP = 4'h1,
    CISE_INC_SKIP = 4'h2,
    CISE_INC = 4'h3,
    CISE_OR_LIT = 4'h4,
    CISE_OR_FILE = 4'h5,
    CISE_BRANCH = 4'h6,
    CISE_IRQ_RET = 4'h7,
    CISE_RET = 4'h8,
    CISE_LIT_RET = 4'h9,
    CISE_ROT_LEFT = 4'ha
  } cise_op_t;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [0:0] {
    CISE_ST_EXEC = 1'b0,
    CISE_ST_FLUSH = 1'b1
  } cise_state_t;

  // ----------------------------------------
  // Widths and field positions
  // ----------------------------------------
  localparam int CISE_DATA_W = 8;
  localparam int CISE_FADDR_W = 7;
  localparam int CISE_PC_W = 15;
  localparam int CISE_BR_W = 11;
  localparam int CISE_LATCH_LO = 3;
  localparam int CISE_LATCH_HI = 6;
  localparam int CISE_IRQ_EN_BIT = 7;
  localparam int CISE_STACK_DEPTH = 16;
  localparam int CISE_SP_W = 4;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] CISE_W_RST = 8'h00;
  localparam logic [14:0] CISE_PC_RST = 15'h0000;
  localparam logic [7:0] CISE_IRQCTL_RST = 8'h00;
endpackage

// ### verilog/cise_exec.sv
// Executor for a subset of an 8-bit core's instructions
// Notes on behaviour
// - File ops use a 7-bit address; dest 0 writes working reg, 1 writes file.
// - Decrement-skip stores f-1; zero result turns next instruction into a no-op.
// - Increment-skip stores f+1; zero result turns next instruction into a no-op.
// - Branch loads 11-bit operand into PC bits 10..0, two cycles, no flags.
// - Branch fills PC bits 14..11 from latch bits 6..3.
// - OR-literal ORs working reg with 8-bit immediate, updates zero flag.
// - Plain increment stores f+1 per destination, updates zero flag, never skips.
// - OR-file ORs working reg with file reg, stores per destination, updates zero.
// - Interrupt return pops stack into PC and sets global enable bit 7.
// - Subroutine return pops stack into PC, two cycles, flags unchanged.
// - Literal return loads immediate into working reg and PC from stack.
// - Rotate left through carry, stores per destination; of the flags only carry changes, one cycle.
`timescale 1ns/10ps
module cise_exec
  import cise_pkg::*;
#(
  parameter int STACK_DEPTH = CISE_STACK_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [3:0] op_code,
  input wire logic [6:0] file_addr,
  input wire logic dest_sel,
  input wire logic [10:0] imm_operand,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] pc_high_latch,
  input wire logic push_valid,
  input wire logic [14:0] push_addr,
  output logic instr_ready,
  output logic file_we,
  output logic [6:0] file_waddr,
  output logic [7:0] file_wdata,
  output logic [7:0] work_reg,
  output logic [14:0] prog_counter,
  output logic [7:0] irq_control_reg,
  output logic zero_flag,
  output logic carry_flag,
  output logic [3:0] stack_ptr
);

  // ----------------------------------------
  // Decode and datapath
  // ----------------------------------------
  cise_state_t state;
  cise_state_t next_state;
  cise_op_t op;
  logic [14:0] ret_stack [STACK_DEPTH];
  logic [14:0] stack_top;
  logic [7:0] result;
  logic result_valid;
  logic take;
  logic skip;
  logic skip_pending;

  assign op = cise_op_t'(op_code);
  assign take = instr_valid && (state == CISE_ST_EXEC);
  assign stack_top = ret_stack[stack_ptr - 4'h1];

  // Result of the file-register ops
  always_comb begin
    result = 8'h00;
    result_valid = 1'b0;
    skip = 1'b0;
    case (op)
      CISE_DEC_SKIP: begin
        result = file_rdata - 8'h01;
        result_valid = 1'b1;
        skip = (result == 8'h00);
      end
      CISE_INC_SKIP: begin
        result = file_rdata + 8'h01;
        result_valid = 1'b1;
        skip = (result == 8'h00);
      end
      CISE_INC: begin
        result = file_rdata + 8'h01;
        result_valid = 1'b1;
      end
      CISE_OR_FILE: begin
        result = work_reg | file_rdata;
        result_valid = 1'b1;
      end
      CISE_ROT_LEFT: begin
        result = {file_rdata[6:0], carry_flag};
        result_valid = 1'b1;
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end

  // Two-cycle ops flush one slot after they are taken
  always_comb begin
    next_state = CISE_ST_EXEC;
    case (state)
      CISE_ST_EXEC: begin
        if (take && (skip || op == CISE_BRANCH || op == CISE_IRQ_RET ||
            op == CISE_RET || op == CISE_LIT_RET)) begin
          next_state = CISE_ST_FLUSH;
        end
      end
      default: begin
        next_state = CISE_ST_EXEC;
      end
    endcase
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // The flush slot is the replacing no-op; upstream sees ready low for it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= CISE_ST_EXEC;
      instr_ready <= 1'b1;
    end else begin
      state <= next_state;
      instr_ready <= (next_state == CISE_ST_EXEC);
    end
  end

  // ----------------------------------------
  // Working register and file write-back
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      work_reg <= CISE_W_RST;
      file_we <= 1'b0;
      file_waddr <= 7'h00;
      file_wdata <= 8'h00;
    end else begin
      file_we <= 1'b0;
      if (take && result_valid) begin
        if (dest_sel) begin
          file_we <= 1'b1;
          file_waddr <= file_addr;
          file_wdata <= result;
        end else begin
          work_reg <= result;
        end
      end else if (take && op == CISE_OR_LIT) begin
        work_reg <= work_reg | imm_operand[7:0];
      end else if (take && op == CISE_LIT_RET) begin
        work_reg <= imm_operand[7:0];
      end
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // Skip ops leave both flags alone even on a zero result
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      zero_flag <= 1'b0;
      carry_flag <= 1'b0;
    end else if (take) begin
      case (op)
        CISE_INC: zero_flag <= (result == 8'h00);
        CISE_OR_FILE: zero_flag <= (result == 8'h00);
        CISE_OR_LIT: zero_flag <= ((work_reg | imm_operand[7:0]) == 8'h00);
        CISE_ROT_LEFT: carry_flag <= file_rdata[7];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Program counter and return stack
  // ----------------------------------------
  // Push port lets the call logic outside fill the stack; wraps when full
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prog_counter <= CISE_PC_RST;
      stack_ptr <= 4'h0;
    end else if (take) begin
      case (op)
        CISE_BRANCH: begin
          prog_counter <= {pc_high_latch[CISE_LATCH_HI:CISE_LATCH_LO],
                           imm_operand};
        end
        CISE_IRQ_RET, CISE_RET, CISE_LIT_RET: begin
          prog_counter <= stack_top;
          stack_ptr <= stack_ptr - 4'h1;
        end
        default: begin
          prog_counter <= prog_counter + 15'h0001;
        end
      endcase
    end else if (state == CISE_ST_FLUSH) begin
      if (skip_pending) begin
        prog_counter <= prog_counter + 15'h0001;
      end
    end else if (push_valid) begin
      stack_ptr <= stack_ptr + 4'h1;
    end
  end

  // Remembers that the flush slot is a skipped instruction, not a jump
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      skip_pending <= 1'b0;
    end else begin
      skip_pending <= take && skip;
    end
  end

  // Stack storage is plain flops; no reset needed for contents
  always_ff @(posedge core_clk) begin
    if (!take && state == CISE_ST_EXEC && push_valid) begin
      ret_stack[stack_ptr] <= push_addr;
    end
  end

  // ----------------------------------------
  // Interrupt control register
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_control_reg <= CISE_IRQCTL_RST;
    end else if (take && op == CISE_IRQ_RET) begin
      irq_control_reg[CISE_IRQ_EN_BIT] <= 1'b1;
    end
  end

endmodule

// ### test/cise_exec_assertions.sv
// Checker: port-level properties of the instruction subset executor
`timescale 1ns/10ps
module cise_exec_assertions
  import cise_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [3:0] op_code,
  input wire logic [10:0] imm_operand,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] pc_high_latch,
  input wire logic instr_ready,
  input wire logic [7:0] work_reg,
  input wire logic [14:0] prog_counter,
  input wire logic [7:0] irq_control_reg,
  input wire logic zero_flag,
  input wire logic carry_flag
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Accepted instruction at this edge
  wire take = instr_valid && instr_ready;
  // Two-cycle ops refuse exactly one slot
  sequence s_flush;
    !instr_ready ##1 instr_ready;
  endsequence
  a_branch_pc: assert property (take && op_code == CISE_BRANCH |=>
    prog_counter == {$past(pc_high_latch[6:3]), $past(imm_operand)}) else $error("bad target");
  a_two_cycle: assert property (take && op_code inside {6, 7, 8, 9} |=> s_flush)
    else $error("bad flush");
  a_irq_enable: assert property (take && op_code == CISE_IRQ_RET |=>
    irq_control_reg[7]) else $error("enable not set");
  a_litret_w: assert property (take && op_code == CISE_LIT_RET |=>
    work_reg == $past(imm_operand[7:0]) && zero_flag == $past(zero_flag))
    else $error("bad literal");
  a_orlit_w: assert property (take && op_code == CISE_OR_LIT |=>
    work_reg == ($past(work_reg) | $past(imm_operand[7:0])) && zero_flag == (work_reg == 8'h00))
    else $error("bad or");
  a_rot_carry: assert property (take && op_code == CISE_ROT_LEFT |=>
    carry_flag == $past(file_rdata[7]) && zero_flag == $past(zero_flag))
    else $error("bad carry");
  a_skip_flags: assert property (take && op_code inside {1, 2} |=>
    zero_flag == $past(zero_flag) && carry_flag == $past(carry_flag)) else $error("flag moved");
  a_inc_noskip: assert property (take && op_code == CISE_INC |=> instr_ready)
    else $error("inc skipped");
  a_skip_zero: assert property (take && ((op_code == CISE_DEC_SKIP && file_rdata == 8'h01) ||
    (op_code == CISE_INC_SKIP && file_rdata == 8'hff)) |=> s_flush) else $error("no skip");
  a_skip_nonzero: assert property (take && ((op_code == CISE_DEC_SKIP && file_rdata != 8'h01) ||
    (op_code == CISE_INC_SKIP && file_rdata != 8'hff)) |=> instr_ready) else $error("false skip");
endmodule

bind cise_exec cise_exec_assertions u_chk (.core_clk, .rst_n, .instr_valid, .op_code,
  .imm_operand, .file_rdata, .pc_high_latch, .instr_ready, .work_reg, .prog_counter,
  .irq_control_reg, .zero_flag, .carry_flag);

// ### test/tb.sv
// Testbench: directed instruction sequences for the subset executor
`timescale 1ns/10ps
module tb
  import cise_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic dest_sel = 1'b0;
  logic push_valid = 1'b0;
  logic [3:0] op_code = 4'h0;
  logic [6:0] file_addr = 7'h7f;
  logic [10:0] imm_operand = 11'h000;
  logic [7:0] file_rdata = 8'h00;
  logic [7:0] pc_high_latch = 8'h00;
  logic [14:0] push_addr = 15'h0000;
  logic instr_ready, file_we, zero_flag, carry_flag;
  logic [6:0] file_waddr;
  logic [7:0] file_wdata, work_reg, irq_control_reg;
  logic [14:0] prog_counter;
  logic [3:0] stack_ptr;
  int n_mismatch = 0;
  int tests_run = 0;

  cise_exec dut (.core_clk, .rst_n, .instr_valid, .op_code, .file_addr, .dest_sel,
    .imm_operand, .file_rdata, .pc_high_latch, .push_valid, .push_addr, .instr_ready,
    .file_we, .file_waddr, .file_wdata, .work_reg, .prog_counter, .irq_control_reg,
    .zero_flag, .carry_flag, .stack_ptr);

  // 50 MHz clock
  initial begin
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask

  // One instruction; waits out any refused flush slot first
  task automatic ex(input cise_op_t op, input logic [10:0] k, input logic [7:0] rd,
      input logic d);
    @(negedge core_clk);
    while (instr_ready !== 1'b1) @(negedge core_clk);
    op_code = op;
    imm_operand = k;
    file_rdata = rd;
    dest_sel = d;
    instr_valid = 1'b1;
    @(negedge core_clk);
    instr_valid = 1'b0;
  endtask

  // Return-address push, kept apart from instruction slots
  task automatic pu(input logic [14:0] a);
    @(negedge core_clk);
    push_addr = a;
    push_valid = 1'b1;
    @(negedge core_clk);
    push_valid = 1'b0;
  endtask

  task automatic tally_and_finish;
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----
  // Stimulus
  // ----
  initial begin
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    ex(CISE_OR_LIT, 11'h05a, 8'h00, 1'b0);
    chk({zero_flag, work_reg}, 16'h005a);
    ex(CISE_INC_SKIP, '0, 8'hff, 1'b1);
    chk({file_we, file_waddr, file_wdata}, 16'hff00);
    chk({instr_ready, work_reg}, 16'h005a);
    ex(CISE_DEC_SKIP, '0, 8'h01, 1'b0);
    chk({instr_ready, work_reg}, 16'h0000);
    ex(CISE_DEC_SKIP, '0, 8'h05, 1'b0);
    chk({instr_ready, work_reg}, 16'h0104);
    ex(CISE_INC, '0, 8'hff, 1'b0);
    chk({instr_ready, zero_flag, work_reg}, 16'h0300);
    ex(CISE_OR_FILE, '0, 8'h81, 1'b1);
    chk({file_we, zero_flag, file_wdata}, 16'h0281);
    ex(CISE_ROT_LEFT, '0, 8'he6, 1'b0);
    chk({carry_flag, work_reg}, 16'h01cc);
    ex(CISE_ROT_LEFT, '0, 8'h00, 1'b1);
    chk({carry_flag, file_wdata}, 16'h0001);
    chk(prog_counter, 16'h000a);
    pc_high_latch = 8'h50;
    ex(CISE_BRANCH, 11'h123, 8'h00, 1'b0);
    chk({instr_ready, prog_counter}, 16'h5123);
    pu(15'h1234);
    chk(stack_ptr, 16'h0001);
    ex(CISE_RET, '0, 8'h00, 1'b0);
    chk(prog_counter, 16'h1234);
    chk(stack_ptr, 16'h0000);
    pu(15'h0abc);
    ex(CISE_IRQ_RET, '0, 8'h00, 1'b0);
    chk({irq_control_reg[7], prog_counter}, 16'h8abc);
    pu(15'h0055);
    ex(CISE_LIT_RET, 11'h03c, 8'h00, 1'b0);
    chk({work_reg, prog_counter[7:0]}, 16'h3c55);
    tally_and_finish;
  end

  // Watchdog: whole sequence needs well under 200 cycles
  initial begin
    repeat (2000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule
